// ---- hdl/flash_tbl_consts.svh ----
// Constants for the serial parameter table tail: link framing and table contents.
`ifndef FLASH_TBL_CONSTS_SVH
`define FLASH_TBL_CONSTS_SVH

// Link framing.
`define TBL_READ_OPCODE 8'h5a
`define TBL_DUMMY_CLOCKS 5'h08
`define TBL_OPC_BITS 5'h08
`define TBL_ADDR_BITS 5'h18
`define TBL_PAGE 20'h00006
`define TBL_BLANK 8'hff

// Line mode select codes.
`define LINE_MODE_1 2'h0
`define LINE_MODE_2 2'h1
`define LINE_MODE_4 2'h2

// Output enable masks per line mode.
`define OE_MASK_1 4'h2
`define OE_MASK_2 4'h3
`define OE_MASK_4 4'hf

// Supply voltage fields.
`define VCC_MAX 16'h2000
`define VCC_MIN 16'h1650

// Capability half-word fields.
`define CAP_HW_RESET 1'h0
`define CAP_PAUSE_PIN 1'h1
`define CAP_DEEP_PD 1'h1
`define CAP_SW_RESET 1'h0
`define CAP_SW_RESET_OPC 8'hff
`define CAP_PGM_SUSPEND 1'h0
`define CAP_ERS_SUSPEND 1'h0
`define CAP_BIT14 1'h1
`define CAP_WRAP_READ 1'h0
`define WRAP_OPC 8'hff
`define WRAP_LEN 8'hff

// Block lock half-word fields.
`define LOCK_BLOCK 1'h1
`define LOCK_NONVOL 1'h0
`define LOCK_OPC 8'h36
`define LOCK_DFLT_UNPROT 1'h0
`define LOCK_OTP 1'h1
`define LOCK_READ 1'h0
`define LOCK_PERM 1'h0
`define LOCK_UNUSED 2'h3

`endif

// ---- hdl/flash_tbl_pkg.sv ----
// Types for the serial parameter table tail.
package flash_tbl_pkg;

  typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA, ST_SKIP} link_state_e;

  typedef struct packed {
    link_state_e state;
    logic sclk_m;
    logic sclk_s;
    logic sclk_p;
    logic cs_m;
    logic cs_s;
    logic [3:0] io_m;
    logic [3:0] io_s;
    logic [2:0] width;
    logic [4:0] cnt;
    logic [23:0] shift;
    logic [23:0] addr;
    logic [7:0] out_sh;
    logic [2:0] obits;
    logic [3:0] o_io;
    logic [3:0] o_oe;
    logic reading;
  } link_s;

endpackage

// ---- hdl/flash_tbl_rom.sv ----
// Constant sixteen-byte table tail with registered read data.
`include "flash_tbl_consts.svh"

module flash_tbl_rom (
  input wire logic i_mclk, // System clock.
  input wire logic i_resetn, // Synchronous reset, active low.
  input wire logic [3:0] i_addr, // Byte offset from 60h.
  output logic [7:0] o_data // Table byte, one cycle after the address.
);

  logic [7:0] data_q;
  logic [7:0] data_d;
  logic [15:0] cap_hw;
  logic [15:0] lock_hw;
  logic [15:0] vcc_max;
  logic [15:0] vcc_min;

  assign vcc_max = `VCC_MAX;
  assign vcc_min = `VCC_MIN;
  assign cap_hw = {`CAP_WRAP_READ, `CAP_BIT14, `CAP_ERS_SUSPEND, `CAP_PGM_SUSPEND,
                   `CAP_SW_RESET_OPC,
                   `CAP_SW_RESET, `CAP_DEEP_PD, `CAP_PAUSE_PIN, `CAP_HW_RESET};
  assign lock_hw = {`LOCK_UNUSED, `LOCK_PERM, `LOCK_READ, `LOCK_OTP, `LOCK_DFLT_UNPROT,
                    `LOCK_OPC, `LOCK_NONVOL, `LOCK_BLOCK};

  // There is no write path at all, so every read of an address returns the same byte.
  always_comb
  begin
    unique case (i_addr)
      4'h0: data_d = vcc_max[7:0];
      4'h1: data_d = vcc_max[15:8];
      4'h2: data_d = vcc_min[7:0];
      4'h3: data_d = vcc_min[15:8];
      4'h4: data_d = cap_hw[7:0];
      4'h5: data_d = cap_hw[15:8];
      4'h6: data_d = `WRAP_OPC;
      4'h7: data_d = `WRAP_LEN;
      4'h8: data_d = lock_hw[7:0];
      4'h9: data_d = lock_hw[15:8];
      default: data_d = `TBL_BLANK;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
      data_q <= `TBL_BLANK;
    else
      data_q <= data_d;
  end

  assign o_data = data_q;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  a_vmax_bytes: assert property ((i_addr == 4'h0) |=> (o_data == 8'h00))
    else $error("maximum supply low byte wrong");
  a_vmin_bytes: assert property ((i_addr == 4'h3) |=> (o_data == 8'h16))
    else $error("minimum supply high byte wrong");
  a_cap_word: assert property ((i_addr == 4'h4) ##1 (i_addr == 4'h5) |=>
    ({o_data, $past(o_data)} == 16'h4ff6))
    else $error("capability half-word wrong");
  a_wrap_blank: assert property ((i_addr inside {4'h6, 4'h7}) |=> (o_data == 8'hff))
    else $error("wrap-around byte not blank");
  a_lock_word: assert property ((i_addr == 4'h8) ##1 (i_addr == 4'h9) |=>
    ({o_data, $past(o_data)} == 16'hc8d9))
    else $error("block lock half-word wrong");
  a_unused_blank: assert property ((i_addr >= 4'ha) |=> (o_data == 8'hff))
    else $error("unused table byte not blank");

endmodule // flash_tbl_rom

// ---- hdl/flash_tbl_link.sv ----
// Serial link slave that answers the table read for the table tail bytes.
`include "flash_tbl_consts.svh"

module flash_tbl_link (
  input wire logic i_mclk, // System clock, 50 MHz.
  input wire logic i_resetn, // Synchronous reset, active low.
  input wire logic i_sclk, // Link clock from the host.
  input wire logic i_cs_n, // Link select, active low.
  input wire logic [3:0] i_io, // Link data lines in.
  input wire logic [1:0] i_line_mode, // Line count: 0 one, 1 two, 2 four.
  output logic [3:0] o_io, // Link data lines out.
  output logic [3:0] o_io_oe, // Output enables, high while driving.
  output logic o_reading // High while table data is being returned.
);

  flash_tbl_pkg::link_s st_q;
  flash_tbl_pkg::link_s st_d;
  logic rise;
  logic fall;
  logic [3:0] lane_in;
  logic [23:0] shift_nx;
  logic [4:0] cnt_nx;
  logic in_table;
  logic [7:0] rom_data;
  logic [7:0] out_src;
  logic [2:0] mode_width;
  logic [3:0] mode_mask;

  // Edges are found on the second synchroniser stage only.
  assign rise = st_q.sclk_s & ~st_q.sclk_p;
  assign fall = ~st_q.sclk_s & st_q.sclk_p;

  always_comb
  begin
    unique case (st_q.width)
      3'h4: lane_in = st_q.io_s;
      3'h2: lane_in = {2'h0, st_q.io_s[1:0]};
      default: lane_in = {3'h0, st_q.io_s[0]};
    endcase
  end

  always_comb
  begin
    unique case (i_line_mode)
      `LINE_MODE_4: mode_width = 3'h4;
      `LINE_MODE_2: mode_width = 3'h2;
      default: mode_width = 3'h1;
    endcase
  end

  always_comb
  begin
    unique case (st_q.width)
      3'h4: mode_mask = `OE_MASK_4;
      3'h2: mode_mask = `OE_MASK_2;
      default: mode_mask = `OE_MASK_1;
    endcase
  end

  assign shift_nx = (st_q.shift << st_q.width) | {20'h00000, lane_in};
  assign cnt_nx = st_q.cnt + {2'h0, st_q.width};
  // Anything outside the tail page is treated as blank table space.
  assign in_table = (st_q.addr[23:4] == `TBL_PAGE);
  assign out_src = (st_q.obits != 3'h0) ? st_q.out_sh : (in_table ? rom_data : `TBL_BLANK);

  flash_tbl_rom u_rom (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_addr(st_q.addr[3:0]),
    .o_data(rom_data)
  );

  always_comb
  begin
    st_d = st_q;
    st_d.sclk_m = i_sclk;
    st_d.sclk_s = st_q.sclk_m;
    st_d.sclk_p = st_q.sclk_s;
    st_d.cs_m = i_cs_n;
    st_d.cs_s = st_q.cs_m;
    st_d.io_m = i_io;
    st_d.io_s = st_q.io_m;
    if (st_q.cs_s)
    begin
      // Line mode is taken while deselected so it cannot change mid-frame.
      st_d.state = flash_tbl_pkg::ST_IDLE;
      st_d.width = mode_width;
      st_d.cnt = 5'h00;
      st_d.shift = 24'h000000;
      st_d.o_oe = 4'h0;
      st_d.o_io = 4'h0;
      st_d.reading = 1'b0;
    end
    else
    begin
      unique case (st_q.state)
        flash_tbl_pkg::ST_IDLE:
        begin
          st_d.state = flash_tbl_pkg::ST_OPC;
        end
        flash_tbl_pkg::ST_OPC:
        begin
          if (rise)
          begin
            st_d.shift = shift_nx;
            st_d.cnt = cnt_nx;
            if (cnt_nx == `TBL_OPC_BITS)
            begin
              st_d.cnt = 5'h00;
              // Any other command, writes included, is ignored to the frame end.
              if (shift_nx[7:0] == `TBL_READ_OPCODE)
                st_d.state = flash_tbl_pkg::ST_ADDR;
              else
                st_d.state = flash_tbl_pkg::ST_SKIP;
            end
          end
        end
        flash_tbl_pkg::ST_ADDR:
        begin
          if (rise)
          begin
            st_d.shift = shift_nx;
            st_d.cnt = cnt_nx;
            if (cnt_nx == `TBL_ADDR_BITS)
            begin
              st_d.addr = shift_nx;
              st_d.cnt = 5'h00;
              st_d.state = flash_tbl_pkg::ST_DUMMY;
            end
          end
        end
        flash_tbl_pkg::ST_DUMMY:
        begin
          if (rise)
          begin
            st_d.cnt = st_q.cnt + 5'h01;
            if (st_q.cnt + 5'h01 == `TBL_DUMMY_CLOCKS)
            begin
              st_d.cnt = 5'h00;
              st_d.obits = 3'h0;
              st_d.state = flash_tbl_pkg::ST_DATA;
            end
          end
        end
        flash_tbl_pkg::ST_DATA:
        begin
          st_d.reading = 1'b1;
          if (fall)
          begin
            unique case (st_q.width)
              3'h4: st_d.o_io = out_src[7:4];
              3'h2: st_d.o_io = {2'h0, out_src[7:6]};
              default: st_d.o_io = {2'h0, out_src[7], 1'b0};
            endcase
            st_d.o_oe = mode_mask;
            st_d.out_sh = out_src << st_q.width;
            st_d.obits = st_q.obits + st_q.width;
            if (st_q.obits == 3'h0)
              st_d.addr = st_q.addr + 24'h000001;
          end
        end
        flash_tbl_pkg::ST_SKIP:
        begin
          st_d.o_oe = 4'h0;
        end
        default:
        begin
          st_d.state = flash_tbl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      // The select stages start at the idle level, so release never looks like a frame start.
      st_q <= '0;
      st_q.cs_m <= 1'b1;
      st_q.cs_s <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  assign o_io = st_q.o_io;
  assign o_io_oe = st_q.o_oe;
  assign o_reading = st_q.reading;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  sequence s_last_dummy;
    (st_q.state == flash_tbl_pkg::ST_DUMMY) && rise && (st_q.cnt == 5'h07) && !st_q.cs_s;
  endsequence

  sequence s_first_drive;
    (st_q.state == flash_tbl_pkg::ST_DATA) && fall && (st_q.obits == 3'h0) && !st_q.cs_s;
  endsequence

  a_deselect_quiet: assert property (st_q.cs_s |=> (o_io_oe == 4'h0))
    else $error("lines driven while deselected");
  a_single_lane: assert property ((st_q.width == 3'h1 && o_io_oe != 4'h0) |->
    (o_io_oe == 4'h2))
    else $error("single-line read drives a wrong lane");
  a_dummy_to_data: assert property (s_last_dummy |=> (st_q.state == flash_tbl_pkg::ST_DATA))
    else $error("data phase not entered after eight dummy clocks");
  a_no_early_drive: assert property ((st_q.state inside {flash_tbl_pkg::ST_ADDR,
    flash_tbl_pkg::ST_DUMMY}) |-> (o_io_oe == 4'h0))
    else $error("lines driven before the dummy clocks end");
  a_foreign_skip: assert property ((st_q.state == flash_tbl_pkg::ST_OPC && rise &&
    !st_q.cs_s && cnt_nx == `TBL_OPC_BITS && shift_nx[7:0] != `TBL_READ_OPCODE) |=>
    (st_q.state == flash_tbl_pkg::ST_SKIP) [*2])
    else $error("foreign command not ignored");
  a_blank_outside: assert property ((s_first_drive ##0 !in_table) |=>
    ((o_io & o_io_oe) == o_io_oe))
    else $error("byte outside the table not blank");
  a_addr_advance: assert property (s_first_drive |=> (st_q.addr == $past(st_q.addr) + 24'h1))
    else $error("read address does not advance per byte");

endmodule // flash_tbl_link

// ---- verification/flash_host_model.sv ----
// Host controller model that issues table reads over the serial link.
`include "flash_tbl_consts.svh"

module flash_host_model (
  input wire logic i_mclk, // System clock, paces the link clock.
  input wire logic [3:0] i_io, // Resolved link data lines.
  input wire logic [3:0] i_io_oe, // Device output enables.
  input wire logic i_reading, // Device data phase flag.
  output logic o_sclk, // Link clock, still outside frames.
  output logic o_cs_n, // Link select, active low.
  output logic [3:0] o_io, // Host data lines.
  output logic [1:0] o_line_mode // Line mode for the frame.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got [0:15];
  int bad_oe;
  int bad_rd;

  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h0;
    o_line_mode = 2'h0;
  end

  task automatic half();
    repeat (4) @(posedge i_mclk);
    #2;
  endtask

  task automatic pulse();
    half();
    o_sclk = 1'b1;
    half();
    o_sclk = 1'b0;
  endtask

  task automatic frame(input logic [1:0] mode, input logic [7:0] opc, input logic [23:0] addr,
                       input int nbytes, input int extra);
    int w;
    logic [31:0] hdr;
    logic [3:0] mask;
    logic [7:0] b;
    logic rd;
    w = (mode == `LINE_MODE_2) ? 2 : (mode == `LINE_MODE_4) ? 4 : 1;
    mask = (w == 2) ? `OE_MASK_2 : (w == 4) ? `OE_MASK_4 : `OE_MASK_1;
    rd = (opc == `TBL_READ_OPCODE);
    hdr = {opc, addr};
    bad_oe = 0;
    bad_rd = 0;
    b = 8'h00;
    o_line_mode = mode;
    half();
    o_cs_n = 1'b0;
    half();
    // Opcode and address on the same lines; no mode bits follow the address.
    for (int i = 0; i < 32; i += w)
    begin
      o_io = 4'h0;
      for (int k = 0; k < w; k++) o_io[w-1-k] = hdr[31-i-k];
      pulse();
    end
    for (int i = 0; i < int'(`TBL_DUMMY_CLOCKS); i++)
    begin
      o_io = ~o_io;
      half();
      if (i_io_oe !== 4'h0) bad_oe++;
      o_sclk = 1'b1;
      half();
      o_sclk = 1'b0;
    end
    for (int n = 0; n < nbytes * 8 / w + extra; n++)
    begin
      // In read frames the host lines toggle so a stale level is never mistaken for data.
      o_io = rd ? ~o_io : 4'h0;
      half();
      if (i_io_oe !== (rd ? mask : 4'h0)) bad_oe++;
      if (i_reading !== rd) bad_rd++;
      for (int k = 0; k < w; k++) b = {b[6:0], (w == 1) ? i_io[1] : i_io[w-1-k]};
      if (((n + 1) * w) % 8 == 0 && n < nbytes * 8 / w) got[(n * w) / 8] = b;
      o_sclk = 1'b1;
      half();
      o_sclk = 1'b0;
    end
    half();
    o_cs_n = 1'b1;
    repeat (6) @(posedge i_mclk);
    #2;
    if (i_io_oe !== 4'h0 || i_reading !== 1'b0) bad_oe++;
    half();
  endtask
endmodule // flash_host_model

// ---- verification/flash_param_table_tail_tb.sv ----
// Self-checking bench for the serial parameter table tail.
`include "flash_tbl_consts.svh"

module flash_param_table_tail_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk;
  logic resetn;
  logic sclk;
  logic cs_n;
  logic [3:0] host_io;
  logic [1:0] line_mode;
  logic [3:0] dut_io;
  logic [3:0] dut_oe;
  logic reading;
  logic [3:0] io_w;
  int errors = 0;
  int n_tests = 0;

  // Each line shows the device where it drives, the host otherwise.
  assign io_w = (dut_io & dut_oe) | (host_io & ~dut_oe);

  flash_tbl_link dut (.i_mclk(mclk), .i_resetn(resetn), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_io(io_w), .i_line_mode(line_mode), .o_io(dut_io), .o_io_oe(dut_oe), .o_reading(reading));

  flash_host_model host (.i_mclk(mclk), .i_io(io_w), .i_io_oe(dut_oe), .i_reading(reading),
    .o_sclk(sclk), .o_cs_n(cs_n), .o_io(host_io), .o_line_mode(line_mode));

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  function automatic logic [7:0] exp_byte(input logic [23:0] a);
    logic [15:0] cap;
    logic [15:0] lock;
    cap = {1'b0, 1'b1, 1'b0, 1'b0, 8'hff, 1'b0, 1'b1, 1'b1, 1'b0};
    lock = {2'b11, 1'b0, 1'b0, 1'b1, 1'b0, 8'h36, 1'b0, 1'b1};
    case (a)
      24'h000060: exp_byte = 8'h00;
      24'h000061: exp_byte = 8'h20;
      24'h000062: exp_byte = 8'h50;
      24'h000063: exp_byte = 8'h16;
      24'h000064: exp_byte = cap[7:0];
      24'h000065: exp_byte = cap[15:8];
      24'h000068: exp_byte = lock[7:0];
      24'h000069: exp_byte = lock[15:8];
      default: exp_byte = 8'hff;
    endcase
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic run(input logic [1:0] mode, input logic [7:0] opc, input logic [23:0] addr,
                     input int nbytes, input int extra);
    host.frame(mode, opc, addr, nbytes, extra);
    if (opc == `TBL_READ_OPCODE)
      for (int i = 0; i < nbytes; i++)
        check(host.got[i], exp_byte(addr + 24'(i)));
    check(host.bad_oe[7:0], 8'h00);
    check(host.bad_rd[7:0], 8'h00);
  endtask

  initial
  begin
    #2000000;
    errors++;
    finish_test();
  end

  initial
  begin
    resetn = 1'b0;
    repeat (3) @(posedge mclk);
    #2;
    resetn = 1'b1;
    check({3'h0, reading, dut_oe}, 8'h00);
    repeat (4) @(posedge mclk);
    #2;
    for (int m = 0; m < 4; m++)
    begin
      run(2'(m), `TBL_READ_OPCODE, 24'h000060, 16, 0);
      $display("test full table in line mode %0d done", m);
    end
    run(`LINE_MODE_4, `TBL_READ_OPCODE, 24'h00005e, 4, 0);
    run(`LINE_MODE_2, `TBL_READ_OPCODE, 24'hfffffe, 3, 0);
    $display("test boundary addresses done");
    // A write attempt must leave the lines released and the contents unchanged.
    run(`LINE_MODE_1, 8'h02, 24'h000060, 2, 0);
    run(`LINE_MODE_1, `TBL_READ_OPCODE, 24'h000060, 16, 0);
    $display("test write attempt done");
    run(`LINE_MODE_4, `TBL_READ_OPCODE, 24'h000064, 1, 1);
    run(`LINE_MODE_4, `TBL_READ_OPCODE, 24'h000064, 2, 0);
    $display("test aborted frame done");
    finish_test();
  end
endmodule // flash_param_table_tail_tb
